/* File: hw/tis_pkg.sv */
package tis_pkg;
// Overview of operation
// - Answer as slave at 8-bit address 0xBC
// - Two offset bytes select one 32-bit word
// - Read-only; ignore other addresses, no bus writes
// - Temperatures signed, half-degree steps
// - Voltages returned in millivolts unscaled
// - Currents returned in milliamperes unscaled
// - Board power returned in milliwatts
// - Board warn/fatal limits read/write at 0x104/0x108
// - Core temp at 0x110, warn limit 0x114
// - Core record thresholds 90 warn, 100 fatal
// - Board record thresholds 75 warn, 85 fatal
// - Module thresholds reported unchanged, not writable
// - Module readings placed from module values
// - Fixed set of twenty sensor records
// - Fixed handles, e.g. 12, 13, 25
// - Poll one sensor every 1 ms step

localparam logic [7:0] DEV_ADDR8 = 8'hBC;
localparam int CLK_PERIOD_NS = 50;
localparam int POLL_STEP_NS = 1000000;
localparam int POLL_STEP_CYC = POLL_STEP_NS / CLK_PERIOD_NS;
localparam int NUM_SENSORS = 20;

localparam logic [15:0] OFF_BOARD_TEMP = 16'h0100;
localparam logic [15:0] OFF_BOARD_WARN = 16'h0104;
localparam logic [15:0] OFF_BOARD_FATAL = 16'h0108;
localparam logic [15:0] OFF_CORE_TEMP = 16'h0110;
localparam logic [15:0] OFF_CORE_WARN = 16'h0114;
localparam logic [15:0] OFF_CORE_MV = 16'h013C;
localparam logic [15:0] OFF_CORE_MA = 16'h0140;
localparam logic [15:0] OFF_SLOT_MV = 16'h0144;
localparam logic [15:0] OFF_SLOT_MA = 16'h0148;
localparam logic [15:0] OFF_1V2_MV = 16'h014C;
localparam logic [15:0] OFF_AUX_MV = 16'h0150;
localparam logic [15:0] OFF_AUX_MA = 16'h0154;
localparam logic [15:0] OFF_1V8_MV = 16'h0158;
localparam logic [15:0] OFF_3V3_MV = 16'h015C;
localparam logic [15:0] OFF_BOARD_MW = 16'h0160;
localparam logic [15:0] OFF_RTA_CORE = 16'h0168;
localparam logic [15:0] OFF_RTA_SERDES = 16'h016C;
localparam logic [15:0] OFF_RTB_CORE = 16'h0170;
localparam logic [15:0] OFF_RTB_SERDES = 16'h0174;

localparam logic [31:0] LIMIT_RST = 32'h00000000;
localparam logic [31:0] CORE_WARN_RST = 32'h0000005A;
localparam logic [31:0] CORE_FATAL_RST = 32'h00000064;
localparam logic [31:0] BOARD_WARN_RST = 32'h0000004B;
localparam logic [31:0] BOARD_FATAL_RST = 32'h00000055;

typedef logic [31:0] tis_word_t;
typedef struct packed {logic valid; logic [15:0] off; tis_word_t data;} tis_lim_wr_s;
typedef struct packed {logic valid; logic is_board; tis_word_t warn; tis_word_t fatal;} tis_thr_wr_s;
typedef struct packed {tis_word_t warn; tis_word_t fatal;} tis_thr_s;
typedef struct packed {logic [15:0] handle; tis_word_t reading; tis_thr_s thr;} tis_rec_s;
typedef struct packed {logic board_warn; logic board_fatal; logic core_warn;} tis_alarm_s;
typedef enum logic [4:0] {
   LS_IDLE = 5'b00001,
   LS_ADDR = 5'b00010,
   LS_OFFH = 5'b00100,
   LS_OFFL = 5'b01000,
   LS_READ = 5'b10000
} tis_link_e;
endpackage

/* File: hw/tis_telemetry_slave.sv */
`timescale 1ns/10ps
module tis_telemetry_slave #(
   parameter int STEP_CYC = tis_pkg::POLL_STEP_CYC
) (
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset
   input wire logic scl_clk, // Bus clock from host
   input wire logic sda_i, // Bus data level
   output logic sda_o, // Bus data out, always low
   output logic sda_oe, // Pull data low
   input tis_pkg::tis_word_t sens_in [tis_pkg::NUM_SENSORS], // Sensor values
   input tis_pkg::tis_thr_s mod_thr [2], // Module thresholds
   input tis_pkg::tis_lim_wr_s lim_wr, // Limit register write
   input tis_pkg::tis_thr_wr_s thr_wr, // Record threshold write
   input wire logic [4:0] rec_idx, // Record lookup index
   output tis_pkg::tis_rec_s rec, // Record lookup result
   output logic [4:0] poll_idx, // Last polled sensor while poll_stb is high, else next sensor to poll
   output logic poll_stb, // Poll step pulse
   output tis_pkg::tis_alarm_s alarm // Limit comparisons
);
   import tis_pkg::*;

   function automatic logic [5:0] off_decode(input logic [15:0] off);
      logic [5:0] r;
      r = 6'h00;
      unique case (off)
         OFF_BOARD_MW: r = 6'h20;
         OFF_SLOT_MA: r = 6'h21;
         OFF_SLOT_MV: r = 6'h22;
         OFF_1V2_MV: r = 6'h23;
         OFF_1V8_MV: r = 6'h24;
         OFF_3V3_MV: r = 6'h25;
         OFF_CORE_MV: r = 6'h26;
         OFF_CORE_MA: r = 6'h27;
         OFF_CORE_TEMP: r = 6'h28;
         OFF_BOARD_TEMP: r = 6'h29;
         OFF_AUX_MA: r = 6'h2C;
         OFF_AUX_MV: r = 6'h2D;
         OFF_RTA_CORE: r = 6'h30;
         OFF_RTA_SERDES: r = 6'h31;
         OFF_RTB_CORE: r = 6'h32;
         OFF_RTB_SERDES: r = 6'h33;
         OFF_BOARD_WARN: r = 6'h34;
         OFF_BOARD_FATAL: r = 6'h35;
         OFF_CORE_WARN: r = 6'h36;
         default: r = 6'h00;
      endcase
      return r;
   endfunction

   function automatic logic [15:0] handle_of(input logic [4:0] idx);
      logic [15:0] h;
      h = 16'h0000;
      unique case (idx)
         5'h00: h = 16'h0001;
         5'h01: h = 16'h0002;
         5'h02: h = 16'h0003;
         5'h03: h = 16'h0004;
         5'h04: h = 16'h0006;
         5'h05: h = 16'h0008;
         5'h06: h = 16'h000A;
         5'h07: h = 16'h000B;
         5'h08: h = 16'h000C;
         5'h09: h = 16'h000D;
         5'h0A: h = 16'h000E;
         5'h0B: h = 16'h000F;
         5'h0C: h = 16'h0018;
         5'h0D: h = 16'h0019;
         5'h0E: h = 16'h0025;
         5'h0F: h = 16'h0026;
         5'h10: h = 16'h002C;
         5'h11: h = 16'h002D;
         5'h12: h = 16'h002E;
         5'h13: h = 16'h002F;
         default: h = 16'h0000;
      endcase
      return h;
   endfunction

   // System clock domain: polling, limits, records
   logic [14:0] tmr_ff;
   logic [14:0] nxt_tmr;
   logic [4:0] pidx_ff;
   logic [4:0] nxt_pidx;
   tis_word_t rd_mem [NUM_SENSORS];
   tis_word_t bwarn_ff;
   tis_word_t bfat_ff;
   tis_word_t cwarn_ff;
   tis_thr_s cthr_ff;
   tis_thr_s bthr_ff;
   tis_rec_s rec_ff;
   tis_alarm_s alarm_ff;
   logic [4:0] poll_idx_ff;
   logic poll_stb_ff;
   logic rq_s1_ff;
   logic rq_s2_ff;
   logic rq_s3_ff;
   logic ack_tgl_ff;
   tis_word_t word_ff;

   // Link domain
   tis_link_e st_ff;
   tis_link_e nxt_st;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [7:0] offh_ff;
   logic [7:0] nxt_offh;
   logic [15:0] off_ff;
   logic [15:0] nxt_off;
   logic req_tgl_ff;
   logic nxt_req;
   tis_word_t txw_ff;
   tis_word_t nxt_txw;
   logic start_tgl_ff;
   logic seen_ff;
   logic ack_s1_ff;
   logic ack_s2_ff;
   logic oe_ff;
   logic sda_o_ff;

   wire step = tmr_ff == 15'(STEP_CYC - 1);
   wire last_sensor = pidx_ff == 5'(NUM_SENSORS - 1);
   wire new_req = rq_s2_ff ^ rq_s3_ff;
   wire [5:0] dec = off_decode(off_ff);
   wire dec_hit = dec[5];
   wire [4:0] dec_idx = dec[4:0];
   wire rec_ok = rec_idx < 5'(NUM_SENSORS);
   wire wr_bwarn = lim_wr.valid && lim_wr.off == OFF_BOARD_WARN;
   wire wr_bfat = lim_wr.valid && lim_wr.off == OFF_BOARD_FATAL;
   wire wr_cwarn = lim_wr.valid && lim_wr.off == OFF_CORE_WARN;
   wire is_mod0 = rec_idx == 5'h0B;
   wire is_mod1 = rec_idx == 5'h0F;

   tis_word_t rword;
   assign rword = !dec_hit ? '0 :
                  dec_idx == 5'h14 ? bwarn_ff :
                  dec_idx == 5'h15 ? bfat_ff :
                  dec_idx == 5'h16 ? cwarn_ff :
                  rd_mem[dec_idx];

   tis_thr_s rec_thr;
   assign rec_thr = is_mod0 ? mod_thr[0] :
                    is_mod1 ? mod_thr[1] :
                    rec_idx == 5'h08 ? cthr_ff :
                    rec_idx == 5'h09 ? bthr_ff :
                    '0;

   assign nxt_tmr = step ? 15'h0000 : tmr_ff + 15'h0001;
   assign nxt_pidx = !step ? pidx_ff : last_sensor ? 5'h00 : pidx_ff + 5'h01;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tmr_ff <= 15'h0000;
         pidx_ff <= 5'h00;
         poll_idx_ff <= 5'h00;
         poll_stb_ff <= 1'b0;
      end else begin
         tmr_ff <= nxt_tmr;
         pidx_ff <= nxt_pidx;
         poll_idx_ff <= pidx_ff;
         poll_stb_ff <= step;
      end
   end

   // Values pass through unscaled; units are those of the sensor front-end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_SENSORS; i++) begin
            rd_mem[i] <= '0;
         end
      end else if (step) begin
         rd_mem[pidx_ff] <= sens_in[pidx_ff];
      end
   end

   // Limits change only from the management side, never from the bus
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bwarn_ff <= LIMIT_RST;
         bfat_ff <= LIMIT_RST;
         cwarn_ff <= LIMIT_RST;
      end else begin
         if (wr_bwarn) bwarn_ff <= lim_wr.data;
         if (wr_bfat) bfat_ff <= lim_wr.data;
         if (wr_cwarn) cwarn_ff <= lim_wr.data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cthr_ff <= '{warn: CORE_WARN_RST, fatal: CORE_FATAL_RST};
         bthr_ff <= '{warn: BOARD_WARN_RST, fatal: BOARD_FATAL_RST};
      end else if (thr_wr.valid && thr_wr.is_board) begin
         bthr_ff <= '{warn: thr_wr.warn, fatal: thr_wr.fatal};
      end else if (thr_wr.valid) begin
         cthr_ff <= '{warn: thr_wr.warn, fatal: thr_wr.fatal};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rec_ff <= '0;
         alarm_ff <= '0;
      end else begin
         rec_ff.handle <= handle_of(rec_idx);
         rec_ff.reading <= rec_ok ? rd_mem[rec_idx] : '0;
         rec_ff.thr <= rec_thr;
         alarm_ff.board_warn <= $signed(rd_mem[9]) >= $signed(bwarn_ff);
         alarm_ff.board_fatal <= $signed(rd_mem[9]) >= $signed(bfat_ff);
         alarm_ff.core_warn <= $signed(rd_mem[8]) >= $signed(cwarn_ff);
      end
   end

   // Offset request crossing; off_ff is held steady while the toggle travels
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rq_s1_ff <= 1'b0;
         rq_s2_ff <= 1'b0;
         rq_s3_ff <= 1'b0;
         ack_tgl_ff <= 1'b0;
         word_ff <= '0;
      end else begin
         rq_s1_ff <= req_tgl_ff;
         rq_s2_ff <= rq_s1_ff;
         rq_s3_ff <= rq_s2_ff;
         if (new_req) begin
            word_ff <= rword;
            ack_tgl_ff <= rq_s2_ff;
         end
      end
   end

   // Start marker: data falls while the bus clock is high
   always_ff @(negedge sda_i or negedge nrst) begin
      if (!nrst) begin
         start_tgl_ff <= 1'b0;
      end else if (scl_clk) begin
         start_tgl_ff <= ~start_tgl_ff;
      end
   end

   // The marker settles three quarters of a bit before the next rising edge, so one
   // capture suffices; a two-stage path would lose the first address bit.
   wire start_ev = start_tgl_ff != seen_ff;
   wire addr_hit = sh_ff[7:1] == DEV_ADDR8[7:1];
   wire word_ready = ack_s2_ff == req_tgl_ff;
   wire ack_slot = cnt_ff == 4'h8;
   wire [2:0] bsel = 3'(4'h7 - cnt_ff);

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_offh = offh_ff;
      nxt_off = off_ff;
      nxt_req = req_tgl_ff;
      nxt_txw = txw_ff;
      if (start_ev) begin
         nxt_st = LS_ADDR;
         nxt_cnt = 4'h1;
         nxt_sh = {7'h00, sda_i};
      end else if (!ack_slot) begin
         nxt_cnt = cnt_ff + 4'h1;
         if (st_ff != LS_READ) nxt_sh = {sh_ff[6:0], sda_i};
      end else begin
         nxt_cnt = 4'h0;
         unique case (st_ff)
            LS_IDLE: nxt_st = LS_IDLE;
            LS_ADDR: begin
               if (!addr_hit) begin
                  nxt_st = LS_IDLE;
               end else if (sh_ff[0]) begin
                  nxt_st = LS_READ;
                  nxt_txw = word_ready ? word_ff : '0;
               end else begin
                  nxt_st = LS_OFFH;
               end
            end
            LS_OFFH: begin
               nxt_offh = sh_ff;
               nxt_st = LS_OFFL;
            end
            LS_OFFL: begin
               nxt_off = {offh_ff, sh_ff};
               nxt_req = ~req_tgl_ff;
               nxt_st = LS_IDLE;
            end
            LS_READ: begin
               if (sda_i) nxt_st = LS_IDLE;
               else nxt_txw = {8'h00, txw_ff[31:8]};
            end
            default: nxt_st = LS_IDLE;
         endcase
      end
   end

   always_ff @(posedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= LS_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         offh_ff <= 8'h00;
         off_ff <= 16'h0000;
         req_tgl_ff <= 1'b0;
         txw_ff <= '0;
         seen_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         offh_ff <= nxt_offh;
         off_ff <= nxt_off;
         req_tgl_ff <= nxt_req;
         txw_ff <= nxt_txw;
         seen_ff <= start_tgl_ff;
         ack_s1_ff <= ack_tgl_ff;
         ack_s2_ff <= ack_s1_ff;
      end
   end

   // Drive on the falling edge so data is stable across the rising edge
   wire do_ack = ack_slot && ((st_ff == LS_ADDR && addr_hit) ||
                 st_ff == LS_OFFH || st_ff == LS_OFFL);
   wire do_low = st_ff == LS_READ && !ack_slot && !txw_ff[bsel];

   always_ff @(negedge scl_clk or negedge nrst) begin
      if (!nrst) begin
         oe_ff <= 1'b0;
         sda_o_ff <= 1'b0;
      end else begin
         oe_ff <= do_ack || do_low;
         sda_o_ff <= 1'b0;
      end
   end

   assign sda_o = sda_o_ff;
   assign sda_oe = oe_ff;
   assign rec = rec_ff;
   assign poll_idx = poll_idx_ff;
   assign poll_stb = poll_stb_ff;
   assign alarm = alarm_ff;

   poll_space_a: assert property (@(posedge clk) disable iff (!nrst)
      poll_stb_ff |=> !poll_stb_ff [*8])
      else $error("poll steps too close");
   poll_store_a: assert property (@(posedge clk) disable iff (!nrst)
      step |=> rd_mem[$past(pidx_ff)] == $past(sens_in[pidx_ff]))
      else $error("polled value not stored");
   limit_write_a: assert property (@(posedge clk) disable iff (!nrst)
      wr_bfat |=> bfat_ff == $past(lim_wr.data))
      else $error("fatal limit not written");
   limit_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      !lim_wr.valid |=> $stable(bwarn_ff) && $stable(cwarn_ff))
      else $error("limit changed without write");
   // Skip the release edge, where the flops still took their reset values
   fatal_alarm_a: assert property (@(posedge clk) disable iff (!nrst)
      nrst |=> alarm_ff.board_fatal == ($signed($past(rd_mem[9])) >= $signed($past(bfat_ff))))
      else $error("board fatal alarm wrong");
   aux_handle_a: assert property (@(posedge clk) disable iff (!nrst)
      rec_idx == 5'h0D |=> rec_ff.handle == 16'h0019)
      else $error("aux voltage handle wrong");
   mod_thr_a: assert property (@(posedge clk) disable iff (!nrst)
      is_mod1 |=> rec_ff.thr == $past(mod_thr[1]))
      else $error("module threshold altered");
   unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
      new_req && !dec_hit |=> word_ff == '0)
      else $error("unmapped offset not zero");
   addr_ack_a: assert property (@(posedge scl_clk) disable iff (!nrst)
      st_ff == LS_ADDR && ack_slot && !start_ev |-> oe_ff == addr_hit)
      else $error("address acknowledge wrong");
   read_shift_a: assert property (@(posedge scl_clk) disable iff (!nrst)
      st_ff == LS_READ && ack_slot && !sda_i && !start_ev
      |=> txw_ff[23:0] == $past(txw_ff[31:8]))
      else $error("read byte order wrong");

   read_done_c: cover property (@(posedge scl_clk) disable iff (!nrst)
      st_ff == LS_READ && ack_slot && sda_i);
   offset_taken_c: cover property (@(posedge clk) disable iff (!nrst)
      new_req && dec_hit);
   poll_wrap_c: cover property (@(posedge clk) disable iff (!nrst)
      step && last_sensor);
   core_alarm_c: cover property (@(posedge clk) disable iff (!nrst)
      alarm_ff.core_warn);
endmodule // tis_telemetry_slave

/* File: bench/tis_host_model.sv */
`timescale 1ns/10ps
module tis_host_model (
   output logic scl_clk, // Bus clock, stands high between frames
   output logic sda_low, // Host pulls the data wire low
   input wire logic sda // Resolved data wire, pulled up
);
   localparam int Q = 40;

   initial begin
      scl_clk = 1'b1;
      sda_low = 1'b0;
   end

   // Data only moves while the clock is low, so no false start or stop
   task automatic bit_io(input logic b, output logic got);
      sda_low = ~b;
      #Q scl_clk = 1'b1;
      #Q got = sda;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   // Serves as both first and repeated start
   task automatic start_bit();
      sda_low = 1'b0;
      #Q scl_clk = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl_clk = 1'b0;
      #Q;
   endtask

   task automatic stop_bit();
      sda_low = 1'b1;
      #Q scl_clk = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask

   task automatic byte_out(input logic [7:0] b, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], g);
      end
      bit_io(1'b1, g);
      ack = ~g;
   endtask

   task automatic byte_in(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, g);
         b[i] = g;
      end
      bit_io(last, g);
   endtask

   task automatic read_reg(input logic [7:0] addr8, input logic [15:0] off,
                           output logic [3:0] acks, output logic [31:0] data);
      logic [7:0] b;
      start_bit();
      byte_out(addr8, acks[3]);
      byte_out(off[15:8], acks[2]);
      byte_out(off[7:0], acks[1]);
      start_bit();
      byte_out(addr8 | 8'h01, acks[0]);
      for (int k = 0; k < 4; k++) begin
         byte_in(k == 3, b);
         data[8*k +: 8] = b;
      end
      stop_bit();
   endtask

   task automatic write_try(input logic [7:0] addr8, input logic [15:0] off,
                            input logic [7:0] val, output logic [3:0] acks);
      start_bit();
      byte_out(addr8, acks[3]);
      byte_out(off[15:8], acks[2]);
      byte_out(off[7:0], acks[1]);
      byte_out(val, acks[0]);
      stop_bit();
   endtask
endmodule // tis_host_model

/* File: bench/telemetry_i2c_register_slave_tb.sv */
`timescale 1ns/10ps
module telemetry_i2c_register_slave_tb;
   import tis_pkg::*;
   localparam int STEP = 10;
   localparam logic [15:0] HND [20] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h6, 16'h8, 16'hA,
      16'hB, 16'hC, 16'hD, 16'hE, 16'hF, 16'h18, 16'h19, 16'h25, 16'h26, 16'h2C, 16'h2D,
      16'h2E, 16'h2F};
   localparam logic [15:0] RD_OFF [16] = '{16'h0100, 16'h0110, 16'h013C, 16'h0140,
      16'h0144, 16'h0148, 16'h014C, 16'h0150, 16'h0154, 16'h0158, 16'h015C, 16'h0160,
      16'h0168, 16'h016C, 16'h0170, 16'h0174};
   localparam int RD_IDX [16] = '{9, 8, 6, 7, 2, 1, 3, 13, 12, 4, 5, 0, 16, 17, 18, 19};
   localparam tis_thr_s MOD0 = '{warn: 32'h00000046, fatal: 32'h00000050};
   localparam tis_thr_s MOD1 = '{warn: 32'h00000048, fatal: 32'h00000052};
   logic clk, nrst, scl_clk, sda_o, sda_oe, host_low, poll_stb;
   wire sda_w;
   tis_word_t sens_in [NUM_SENSORS];
   tis_thr_s mod_thr [2];
   tis_lim_wr_s lim_wr;
   tis_thr_wr_s thr_wr;
   logic [4:0] rec_idx, poll_idx;
   tis_rec_s rec;
   tis_alarm_s alarm;
   tis_thr_s et;
   logic [3:0] acks;
   logic [31:0] d;
   int err_total = 0;
   int checked = 0;
   int n;

   // Pull-up: the wire is low only while someone pulls it
   assign sda_w = ~(host_low | (sda_oe & ~sda_o));

   tis_host_model host (.scl_clk(scl_clk), .sda_low(host_low), .sda(sda_w));

   tis_telemetry_slave #(.STEP_CYC(STEP)) DUT (.clk(clk), .nrst(nrst), .scl_clk(scl_clk),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .sens_in(sens_in), .mod_thr(mod_thr),
      .lim_wr(lim_wr), .thr_wr(thr_wr), .rec_idx(rec_idx), .rec(rec), .poll_idx(poll_idx),
      .poll_stb(poll_stb), .alarm(alarm));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Distinct bytes expose any byte-order slip; two temperatures get signed values
   function automatic logic [31:0] exp_sens(input int i);
      if (i == 8) return 32'hFFFFFFF0;
      if (i == 9) return 32'h00000072;
      return {24'h123456, 8'(i)};
   endfunction

   function automatic tis_thr_s exp_thr(input int i);
      if (i == 8) return '{warn: 32'h0000005A, fatal: 32'h00000064};
      if (i == 9) return '{warn: 32'h0000004B, fatal: 32'h00000055};
      if (i == 11) return MOD0;
      if (i == 15) return MOD1;
      return '0;
   endfunction

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic bus_chk(input logic [15:0] off, input logic [31:0] exp);
      host.read_reg(8'hBC, off, acks, d);
      chk_word("bus acks", 32'hF, 32'(acks));
      chk_word("bus word", exp, d);
   endtask

   task automatic lim_put(input logic [15:0] off, input logic [31:0] val);
      @(posedge clk);
      lim_wr <= '{valid: 1'b1, off: off, data: val};
      @(posedge clk);
      lim_wr <= '0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic rec_at(input int i);
      @(posedge clk);
      rec_idx <= 5'(i);
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic close_out();
      if (err_total == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      err_total++;
      close_out();
   end

   initial begin
      nrst = 1'b0;
      lim_wr = '0;
      thr_wr = '0;
      rec_idx = 5'h00;
      // Both modules are modelled present with monitoring, so their values count
      mod_thr[0] = MOD0;
      mod_thr[1] = MOD1;
      for (int i = 0; i < NUM_SENSORS; i++) begin
         sens_in[i] = exp_sens(i);
      end
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (poll_stb !== 1'b1 && n < 4 * STEP);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (poll_stb !== 1'b1 && n < 4 * STEP);
      chk_word("poll spacing", 32'(STEP), 32'(n));
      chk_word("poll index", 32'h1, 32'(poll_idx));
      repeat (22 * STEP) @(posedge clk);
      for (int i = 0; i < NUM_SENSORS; i++) begin
         rec_at(i);
         et = exp_thr(i);
         chk_word("record handle", 32'(HND[i]), 32'(rec.handle));
         chk_word("record reading", exp_sens(i), rec.reading);
         chk_word("record warn", et.warn, rec.thr.warn);
         chk_word("record fatal", et.fatal, rec.thr.fatal);
      end
      rec_at(20);
      chk_word("record past end", 32'h0, 32'(rec.handle));
      for (int k = 0; k < 16; k++) begin
         bus_chk(RD_OFF[k], exp_sens(RD_IDX[k]));
      end
      bus_chk(16'h0104, 32'h0);
      lim_put(16'h0104, 32'h00000064);
      lim_put(16'h0108, 32'h00000080);
      lim_put(16'h0114, 32'h00000000);
      lim_put(16'h0100, 32'h00000055);
      bus_chk(16'h0104, 32'h00000064);
      bus_chk(16'h0108, 32'h00000080);
      bus_chk(16'h0114, 32'h00000000);
      bus_chk(16'h0100, 32'h00000072);
      chk_flag("board warn", 1'b1, alarm.board_warn);
      chk_flag("board fatal", 1'b0, alarm.board_fatal);
      chk_flag("core warn", 1'b0, alarm.core_warn);
      lim_put(16'h0108, 32'h00000072);
      lim_put(16'h0114, 32'hFFFFFFF0);
      chk_flag("board fatal equal", 1'b1, alarm.board_fatal);
      chk_flag("core warn signed", 1'b1, alarm.core_warn);
      @(posedge clk);
      thr_wr <= '{valid: 1'b1, is_board: 1'b1, warn: 32'h4C, fatal: 32'h56};
      @(posedge clk);
      thr_wr <= '0;
      rec_at(9);
      chk_word("board warn set", 32'h4C, rec.thr.warn);
      chk_word("board fatal set", 32'h56, rec.thr.fatal);
      rec_at(8);
      chk_word("core warn kept", 32'h5A, rec.thr.warn);
      host.write_try(8'hBC, 16'h0104, 8'hFF, acks);
      chk_word("write acks", 32'hE, 32'(acks));
      bus_chk(16'h0104, 32'h00000064);
      host.read_reg(8'hBE, 16'h0100, acks, d);
      chk_word("foreign acks", 32'h0, 32'(acks));
      chk_word("foreign word", 32'hFFFFFFFF, d);
      bus_chk(16'h010C, 32'h0);
      bus_chk(16'h0000, 32'h0);
      // Second reset mid-run must clear limits and alarms
      @(posedge clk);
      nrst <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk_word("alarm in reset", 32'h0, 32'(alarm));
      @(posedge clk);
      nrst <= 1'b1;
      bus_chk(16'h0108, 32'h0);
      close_out();
   end
endmodule // telemetry_i2c_register_slave_tb
